// >>> common/atq_conv_if.sv
`timescale 1ns/1ns
interface atq_conv_if;
	import atq_pkg::*;
	logic start;
	logic [CH_W-1:0] chan;
	logic bipolar;
	logic vld;
	logic [SMP_W-1:0] data;
	logic ovs;
	modport seq (output start, output chan, output bipolar, input vld, input data, input ovs);
	modport conv (input start, input chan, input bipolar, output vld, output data, output ovs);
endinterface : atq_conv_if

// >>> common/atq_pkg.sv
package atq_pkg;
	localparam int ADR_W = 8;
	localparam int SMP_W = 16;
	localparam int CH_W = 4;
	localparam int CNT_W = 24;

	localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [ADR_W-1:0] OFS_SMP_DIV = 8'h10;
	localparam logic [ADR_W-1:0] OFS_RETRIG_DIV = 8'h14;
	localparam logic [ADR_W-1:0] OFS_CHAN_CNT = 8'h18;
	localparam logic [ADR_W-1:0] OFS_SCAN_CNT = 8'h1c;
	localparam logic [ADR_W-1:0] OFS_POST_CNT = 8'h20;
	localparam logic [ADR_W-1:0] OFS_BLK_SIZE = 8'h24;
	localparam logic [ADR_W-1:0] OFS_BLK_ACK = 8'h28;

	// CTRL fields
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_SCAN_EN = 2;
	localparam int CTRL_TRIG_ANA = 3;
	localparam int CTRL_TRIG_FALL = 4;
	localparam int CTRL_BIPOLAR = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

	// Interrupt status fields
	localparam int IRQ_OVS = 0;
	localparam int IRQ_FIFO_OVF = 1;
	localparam int IRQ_HOST_OVF = 2;
	localparam int IRQ_DONE = 3;
	localparam int IRQ_TRIG = 4;
	localparam int IRQ_W = 5;
	localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
	localparam logic [IRQ_W-1:0] IRQ_ERR_MASK = 5'h07;

	localparam logic [CNT_W-1:0] SMP_DIV_RST = 24'h0000ff;
	localparam logic [CNT_W-1:0] RETRIG_DIV_RST = 24'h00ffff;
	localparam logic [CH_W-1:0] CHAN_CNT_RST = 4'h0;
	localparam logic [CNT_W-1:0] SCAN_CNT_RST = 24'h000001;
	localparam logic [CNT_W-1:0] POST_CNT_RST = 24'h000100;
	localparam logic [CNT_W-1:0] BLK_SIZE_RST = 24'h000040;

	typedef enum logic [1:0] {
		ATQ_IDLE = 2'b00,
		ATQ_ACQ = 2'b01,
		ATQ_WAIT = 2'b11
	} atq_state_t;
endpackage : atq_pkg

// >>> rtl/atq_acq_ctrl.sv
`timescale 1ns/1ns
module atq_acq_ctrl #(
	parameter int RES = 16
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [atq_pkg::ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic EXT_TRIG,
	input wire logic ANA_TRIG,
	output logic ADC_CONVST,
	output logic [atq_pkg::CH_W-1:0] ADC_CHAN,
	input wire logic ADC_DONE,
	input wire logic [atq_pkg::SMP_W-1:0] ADC_DATA,
	input wire logic FIFO_FULL,
	output logic SMP_VALID,
	output logic [atq_pkg::SMP_W-1:0] SMP_DATA,
	output logic [atq_pkg::CH_W-1:0] SMP_CHAN,
	output logic SMP_POST,
	output logic IRQ
);
	import atq_pkg::*;

	atq_conv_if cif ();

	atq_state_t state_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [IRQ_W-1:0] stat_q, mask_q, stat_set;
	logic [CNT_W-1:0] smp_div_q, retrig_div_q, scan_cnt_q, post_cnt_q, blk_size_q;
	logic [CH_W-1:0] chan_cnt_q, chan_q, inflight_q;
	logic [CNT_W-1:0] scan_q, post_done_q, blk_q;
	logic post_q, blk_pend_q, inflight_post_q;
	logic dig_s1_q, dig_s2_q, ana_s1_q, ana_s2_q, trig_prev_q;
	logic wr, rd_fire, start_cmd, stop_cmd, blk_ack_cmd;
	logic smp_tick, retrig_tick, trig_lvl, trig_evt, post_now;
	logic run, err_now, err_any, last_chan, last_scan, done_evt, blk_evt, emit;

	atq_div #(.W(CNT_W)) u_smp_div (
		.clk(MCLK),
		.rstn(RSTN),
		.run(state_q == ATQ_ACQ),
		.div(smp_div_q),
		.tick(smp_tick)
	);

	atq_div #(.W(CNT_W)) u_retrig_div (
		.clk(MCLK),
		.rstn(RSTN),
		.run(run && ctrl_q[CTRL_SCAN_EN]),
		.div(retrig_div_q),
		.tick(retrig_tick)
	);

	atq_conv #(.RES(RES)) u_conv (
		.clk(MCLK),
		.rstn(RSTN),
		.cif(cif.conv),
		.adc_done(ADC_DONE),
		.adc_data(ADC_DATA),
		.adc_convst(ADC_CONVST),
		.adc_chan(ADC_CHAN)
	);

	// Register bus: one wait state; write acts on the edge where ACK is high, read data is latched on the edge before, while ACK is low
	assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
	assign rd_fire = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign start_cmd = wr && WB_ADR_I == OFS_CTRL && WB_DAT_I[CTRL_START];
	assign stop_cmd = wr && WB_ADR_I == OFS_CTRL && WB_DAT_I[CTRL_STOP];
	assign blk_ack_cmd = wr && WB_ADR_I == OFS_BLK_ACK && WB_DAT_I[0];

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			WB_DAT_O <= '0;
		end else if (rd_fire) begin
			unique case (WB_ADR_I)
				OFS_CTRL: WB_DAT_O <= 32'(ctrl_q);
				OFS_STATUS: WB_DAT_O <= {20'h00000, chan_q, 5'h00, blk_pend_q, post_q, run};
				OFS_IRQ_STAT: WB_DAT_O <= 32'(stat_q);
				OFS_IRQ_MASK: WB_DAT_O <= 32'(mask_q);
				OFS_SMP_DIV: WB_DAT_O <= 32'(smp_div_q);
				OFS_RETRIG_DIV: WB_DAT_O <= 32'(retrig_div_q);
				OFS_CHAN_CNT: WB_DAT_O <= 32'(chan_cnt_q);
				OFS_SCAN_CNT: WB_DAT_O <= 32'(scan_cnt_q);
				OFS_POST_CNT: WB_DAT_O <= 32'(post_cnt_q);
				OFS_BLK_SIZE: WB_DAT_O <= 32'(blk_size_q);
				default: WB_DAT_O <= '0;
			endcase
		end
	end

	// Configuration registers; start and stop bits are commands and never stored
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			ctrl_q <= CTRL_RST;
			mask_q <= IRQ_RST;
			smp_div_q <= SMP_DIV_RST;
			retrig_div_q <= RETRIG_DIV_RST;
			chan_cnt_q <= CHAN_CNT_RST;
			scan_cnt_q <= SCAN_CNT_RST;
			post_cnt_q <= POST_CNT_RST;
			blk_size_q <= BLK_SIZE_RST;
		end else if (wr) begin
			unique case (WB_ADR_I)
				OFS_CTRL: ctrl_q <= WB_DAT_I[CTRL_W-1:0] & ~CTRL_W'(3);
				OFS_IRQ_MASK: mask_q <= WB_DAT_I[IRQ_W-1:0];
				OFS_SMP_DIV: smp_div_q <= WB_DAT_I[CNT_W-1:0];
				OFS_RETRIG_DIV: retrig_div_q <= WB_DAT_I[CNT_W-1:0];
				OFS_CHAN_CNT: chan_cnt_q <= WB_DAT_I[CH_W-1:0];
				OFS_SCAN_CNT: scan_cnt_q <= WB_DAT_I[CNT_W-1:0];
				OFS_POST_CNT: post_cnt_q <= WB_DAT_I[CNT_W-1:0];
				OFS_BLK_SIZE: blk_size_q <= WB_DAT_I[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// Trigger pins are asynchronous; the edge is taken on the second stage only
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			dig_s1_q <= 1'b0;
			dig_s2_q <= 1'b0;
			ana_s1_q <= 1'b0;
			ana_s2_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			dig_s1_q <= EXT_TRIG;
			dig_s2_q <= dig_s1_q;
			ana_s1_q <= ANA_TRIG;
			ana_s2_q <= ana_s1_q;
			trig_prev_q <= trig_lvl;
		end
	end

	assign trig_lvl = ctrl_q[CTRL_TRIG_ANA] ? ana_s2_q : dig_s2_q;
	assign trig_evt = ctrl_q[CTRL_TRIG_FALL] ? (trig_prev_q && !trig_lvl) : (!trig_prev_q && trig_lvl);
	assign post_now = run && !post_q && trig_evt;

	assign run = state_q != ATQ_IDLE;
	assign last_chan = chan_q >= chan_cnt_q;
	assign last_scan = scan_q + 1'b1 >= scan_cnt_q;
	assign emit = cif.vld && run;
	assign done_evt = emit && inflight_post_q && post_done_q + 1'b1 >= post_cnt_q;
	assign blk_evt = emit && blk_q + 1'b1 >= blk_size_q;

	always_comb begin
		stat_set = '0;
		stat_set[IRQ_OVS] = cif.ovs && run;
		// Once raised, a still full FIFO keeps the flag up after the halt, so a clear cannot stick
		stat_set[IRQ_FIFO_OVF] = FIFO_FULL && (run || stat_q[IRQ_FIFO_OVF]);
		stat_set[IRQ_HOST_OVF] = blk_evt && blk_pend_q && !blk_ack_cmd;
		stat_set[IRQ_DONE] = done_evt;
		stat_set[IRQ_TRIG] = post_now;
	end

	assign err_now = |(stat_set & IRQ_ERR_MASK);
	assign err_any = |(stat_q & IRQ_ERR_MASK);

	// Write one to clear; a hardware set in the same cycle wins, so a persisting full keeps it set
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			stat_q <= IRQ_RST;
		end else begin
			stat_q <= (stat_q & ~((wr && WB_ADR_I == OFS_IRQ_STAT) ? WB_DAT_I[IRQ_W-1:0] : '0)) | stat_set;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(stat_q & mask_q);
		end
	end

	// Sequencer; a start is refused while an error flag is still pending
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			state_q <= ATQ_IDLE;
			chan_q <= '0;
			scan_q <= '0;
		end else if (err_now || stop_cmd || done_evt) begin
			state_q <= ATQ_IDLE;
		end else if (start_cmd && !run && !err_any) begin
			state_q <= ATQ_ACQ;
			chan_q <= '0;
			scan_q <= '0;
		end else begin
			unique case (state_q)
				ATQ_IDLE: ;
				ATQ_ACQ: if (smp_tick) begin
					chan_q <= last_chan ? '0 : chan_q + 1'b1;
					if (last_chan) begin
						scan_q <= last_scan ? '0 : scan_q + 1'b1;
						if (ctrl_q[CTRL_SCAN_EN] && last_scan) begin
							state_q <= ATQ_WAIT;
						end
					end
				end
				ATQ_WAIT: if (retrig_tick) begin
					state_q <= ATQ_ACQ;
				end
			endcase
		end
	end

	assign cif.start = state_q == ATQ_ACQ && smp_tick && !err_any;
	assign cif.chan = chan_q;
	assign cif.bipolar = ctrl_q[CTRL_BIPOLAR];

	// Post label is set once per operation and only a fresh start clears it
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			post_q <= 1'b0;
		end else if (start_cmd && !run && !err_any) begin
			post_q <= 1'b0;
		end else if (post_now) begin
			post_q <= 1'b1;
		end
	end

	// A sample is labelled by the phase at the moment its conversion was started
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			inflight_q <= '0;
			inflight_post_q <= 1'b0;
		end else if (cif.start) begin
			inflight_q <= chan_q;
			inflight_post_q <= post_q || post_now;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			post_done_q <= '0;
		end else if (start_cmd && !run) begin
			post_done_q <= '0;
		end else if (emit && inflight_post_q) begin
			post_done_q <= post_done_q + 1'b1;
		end
	end

	// Host block tracking; a block finished while the previous one is unread is an overflow
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			blk_q <= '0;
			blk_pend_q <= 1'b0;
		end else begin
			if (start_cmd && !run) begin
				blk_q <= '0;
			end else if (emit) begin
				blk_q <= blk_evt ? '0 : blk_q + 1'b1;
			end
			if (blk_evt) begin
				blk_pend_q <= 1'b1;
			end else if (blk_ack_cmd) begin
				blk_pend_q <= 1'b0;
			end
		end
	end

	// Transfer toward the host stops as soon as an error is raised
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			SMP_VALID <= 1'b0;
			SMP_DATA <= '0;
			SMP_CHAN <= '0;
			SMP_POST <= 1'b0;
		end else begin
			SMP_VALID <= emit && !err_now && !err_any;
			if (emit) begin
				SMP_DATA <= cif.data;
				SMP_CHAN <= inflight_q;
				SMP_POST <= inflight_post_q;
			end
		end
	end
endmodule : atq_acq_ctrl

// >>> rtl/atq_conv.sv
`timescale 1ns/1ns
module atq_conv #(
	parameter int RES = 16
) (
	input wire logic clk,
	input wire logic rstn,
	atq_conv_if.conv cif,
	input wire logic adc_done,
	input wire logic [atq_pkg::SMP_W-1:0] adc_data,
	output logic adc_convst,
	output logic [atq_pkg::CH_W-1:0] adc_chan
);
	import atq_pkg::*;
	logic done_s1_q, done_s2_q, done_s3_q, busy_q;
	logic done_evt;
	logic [SMP_W-1:0] raw;

	if (RES != 12 && RES != 16) begin : g_bad_res
		$error("atq_conv: RES must be 12 or 16");
	end

	assign done_evt = done_s2_q && !done_s3_q;
	assign raw = adc_data & SMP_W'((1 << RES) - 1);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
		end else begin
			done_s1_q <= adc_done;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
		end
	end

	// A finishing conversion frees the converter in the same cycle a new pulse comes in
	always_ff @(posedge clk) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			adc_convst <= 1'b0;
			adc_chan <= '0;
			cif.ovs <= 1'b0;
		end else begin
			adc_convst <= 1'b0;
			cif.ovs <= 1'b0;
			if (cif.start && busy_q && !done_evt) begin
				cif.ovs <= 1'b1;
			end else if (cif.start) begin
				adc_convst <= 1'b1;
				adc_chan <= cif.chan;
				busy_q <= 1'b1;
			end else if (done_evt) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Converter delivers two's complement in bipolar ranges; flipping the top bit yields offset binary
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cif.vld <= 1'b0;
			cif.data <= '0;
		end else begin
			cif.vld <= done_evt;
			if (done_evt) begin
				if (cif.bipolar) begin
					cif.data <= raw ^ SMP_W'(1 << (RES - 1));
				end else begin
					cif.data <= raw;
				end
			end
		end
	end
endmodule : atq_conv

// >>> rtl/atq_div.sv
`timescale 1ns/1ns
module atq_div #(
	parameter int W = 24
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [W-1:0] div,
	output logic tick
);
	import atq_pkg::*;
	logic [W-1:0] cnt_q;

	if (W < 2) begin : g_bad_width
		$error("atq_div: W too small");
	end

	// Period is div+1 cycles; restarts with the operation so the first tick is predictable
	always_ff @(posedge clk) begin
		if (!rstn || !run) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (cnt_q >= div) begin
			cnt_q <= '0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : atq_div

// >>> tb/atq_acq_props.sv
`timescale 1ns/1ns
module atq_acq_props
	import atq_pkg::*;
#(
	parameter int RES = 16
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic WB_WE_I,
	input wire logic [ADR_W-1:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic WB_ACK_O,
	input wire logic ADC_CONVST,
	input wire logic [CH_W-1:0] ADC_CHAN,
	input wire logic ADC_DONE,
	input wire logic [SMP_W-1:0] ADC_DATA,
	input wire logic FIFO_FULL,
	input wire logic SMP_VALID,
	input wire logic [SMP_W-1:0] SMP_DATA,
	input wire logic [CH_W-1:0] SMP_CHAN,
	input wire logic SMP_POST,
	input wire logic IRQ
);
	logic wr_hit, start_wr, done_q, bip_q, post_q;
	logic [CH_W-1:0] chan_q;
	logic [SMP_W-1:0] data_q;
	// Writes land on the ack edge, so ack marks when a register changes
	assign wr_hit = WB_WE_I & WB_ACK_O;
	assign start_wr = wr_hit & (WB_ADR_I == OFS_CTRL) & WB_DAT_I[CTRL_START];
	always_ff @(posedge MCLK) begin
		done_q <= ADC_DONE;
		if (ADC_DONE & ~done_q)
			data_q <= ADC_DATA;
		if (ADC_CONVST)
			chan_q <= ADC_CHAN;
	end
	always_ff @(posedge MCLK) begin
		if (!RSTN)
			bip_q <= 1'b0;
		else if (wr_hit & (WB_ADR_I == OFS_CTRL))
			bip_q <= WB_DAT_I[CTRL_BIPOLAR];
	end
	always_ff @(posedge MCLK) begin
		if (!RSTN | start_wr)
			post_q <= 1'b0;
		else if (SMP_VALID & SMP_POST)
			post_q <= 1'b1;
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	sequence s_start;
		start_wr;
	endsequence
	sequence s_full_rise;
		!FIFO_FULL ##1 FIFO_FULL;
	endsequence
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	a_start_conv: assert property (s_start |-> ##[1:120] ADC_CONVST)
		else $error("no conversion after start");
	a_smp_after_done: assert property (SMP_VALID |-> $past(ADC_DONE, 4) && !$past(ADC_DONE, 5))
		else $error("sample not tied to done");
	a_smp_chan: assert property (SMP_VALID |-> SMP_CHAN == chan_q)
		else $error("sample channel wrong");
	a_smp_code: assert property (SMP_VALID |-> SMP_DATA == (data_q ^ (SMP_W'(bip_q) << (RES - 1))))
		else $error("sample coding wrong");
	a_post_sticky: assert property (SMP_VALID && post_q |-> SMP_POST)
		else $error("post label reverted");
	a_full_halt: assert property (s_full_rise |-> ##3 !ADC_CONVST [*8])
		else $error("conversion after fifo full");
	a_irq_hold: assert property ($fell(IRQ) |-> $past(wr_hit) || $past(wr_hit, 2) || $past(wr_hit, 3))
		else $error("irq dropped without clear");
endmodule : atq_acq_props

// >>> tb/atq_adc_model.sv
`timescale 1ns/1ns
module atq_adc_model (
	input wire logic clk,
	input wire logic convst,
	input wire logic [3:0] chan,
	input wire logic slow,
	output logic done,
	output logic [15:0] data
);
	logic [4:0] cnt = '0;
	logic [2:0] hold = '0;
	logic [15:0] lat = '0;
	initial done = 1'b0;
	initial data = '0;
	always @(posedge clk) begin
		if (cnt != 0)
			cnt <= cnt - 1;
		else if (convst) begin
			cnt <= slow ? 5'd20 : 5'd3;
			lat <= {chan, 12'h5a3};
		end
		if (cnt == 1) begin
			done <= 1'b1;
			data <= lat;
			hold <= 3'd5;
		end else if (hold != 0)
			hold <= hold - 1;
		if (hold == 4)
			done <= 1'b0;
		// Past the hold time the bus shows junk, not the old word
		if (hold == 1)
			data <= ~data;
	end
endmodule : atq_adc_model

// >>> tb/tb_about_trigger_acq_control.sv
`timescale 1ns/1ns
module tb_about_trigger_acq_control;
	import atq_pkg::*;
	logic MCLK = 0, RSTN = 0, req = 0, we = 0, ext = 0, ana = 0, full = 0, slow = 0, bip = 0, scan = 0;
	logic [ADR_W-1:0] adr = '0;
	logic [31:0] dat = '0, rd, dout, seed = 32'h50027bfe;
	logic [CH_W-1:0] exp_ch = '0, last = '0, achan, schan;
	logic [SMP_W-1:0] adata, sdata;
	logic ack, conv, done, sv, spost, irq;
	logic [19:0] notes[$];
	int failures = 0, tests_run = 0, post_n = 0, pre_n = 0, run_len = 0, gap = 0;
	always #2 MCLK = ~MCLK;
	atq_acq_ctrl dut (.MCLK(MCLK), .RSTN(RSTN), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .EXT_TRIG(ext), .ANA_TRIG(ana),
		.ADC_CONVST(conv), .ADC_CHAN(achan), .ADC_DONE(done), .ADC_DATA(adata), .FIFO_FULL(full),
		.SMP_VALID(sv), .SMP_DATA(sdata), .SMP_CHAN(schan), .SMP_POST(spost), .IRQ(irq));
	atq_adc_model adc (.clk(MCLK), .convst(conv), .chan(achan), .slow(slow), .done(done), .data(adata));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task summarize();
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge MCLK);
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge MCLK);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dout;
		req <= 1'b0;
		check(32'(n < 20), 1);
	endtask : wb
	task wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge MCLK);
			n++;
		end
		check(32'(irq), 1);
	endtask : wait_irq
	task run(input int i);
		logic [31:0] c;
		last = (i == 2) ? 4'h1 : 4'h2;
		bip = (i == 1);
		scan = (i == 2);
		wb(1'b1, OFS_CHAN_CNT, 32'(last));
		ext <= (i == 1);
		ana <= 1'b0;
		c = (32'h1 << CTRL_START) | (32'(bip) << CTRL_BIPOLAR) | (32'(scan) << CTRL_SCAN_EN)
			| (32'(scan) << CTRL_TRIG_ANA) | (32'(i == 1) << CTRL_TRIG_FALL);
		exp_ch = '0;
		post_n = 0;
		pre_n = 0;
		run_len = 0;
		wb(1'b1, OFS_CTRL, c);
		repeat (150 + xs() % 64) @(posedge MCLK);
		ext <= (i != 1);
		ana <= scan;
		wait_irq();
		repeat (40) @(posedge MCLK);
		check(32'(post_n), 6);
		check(32'(pre_n > 0), 1);
		wb(1'b0, OFS_IRQ_STAT, 0);
		check(rd & 32'h1f, 32'h18);
		wb(1'b1, OFS_IRQ_STAT, 32'h1f);
	endtask : run
	task fresh();
		exp_ch = '0;
		post_n = 0;
		run_len = 0;
		scan = 1'b0;
	endtask : fresh
	task halt();
		fresh();
		wb(1'b1, OFS_CTRL, 32'h1 << CTRL_START);
		repeat (60) @(posedge MCLK);
		wb(1'b0, OFS_STATUS, 0);
		check(rd & 32'h1, 32'h1);
		wb(1'b1, OFS_CTRL, 32'h1 << CTRL_STOP);
		repeat (40) @(posedge MCLK);
		// A conversion launched on the stop edge never returns a sample
		notes.delete();
		check(32'(gap >= 38), 1);
		wb(1'b0, OFS_STATUS, 0);
		check(rd & 32'h3, 0);
	endtask : halt
	task err(input int b, input logic f);
		fresh();
		wb(1'b1, OFS_IRQ_MASK, 32'h1 << b);
		wb(1'b1, OFS_CTRL, 32'h1 << CTRL_START);
		if (f) begin
			repeat (30) @(posedge MCLK);
			full <= 1'b1;
		end
		wait_irq();
		notes.delete();
		repeat (40) @(posedge MCLK);
		check(32'(gap >= 38), 1);
		check(32'(irq), 1);
		wb(1'b1, OFS_IRQ_STAT, 32'h7);
		wb(1'b0, OFS_IRQ_STAT, 0);
		check(rd & 32'h7, 32'(f) << 1);
		full <= 1'b0;
		wb(1'b1, OFS_IRQ_STAT, 32'h7);
		wb(1'b0, OFS_IRQ_STAT, 0);
		check(rd & 32'h7, 0);
	endtask : err
	always @(posedge MCLK) begin
		gap++;
		if (conv === 1'b1) begin
			check(32'(achan), 32'(exp_ch));
			notes.push_back({exp_ch, exp_ch, 12'h5a3} ^ {4'h0, bip, 15'h0});
			if (scan && gap > 12 && run_len != 0)
				check(32'(run_len), 4);
			run_len = (gap > 12) ? 1 : run_len + 1;
			gap = 0;
			exp_ch = (exp_ch == last) ? 4'h0 : exp_ch + 4'h1;
		end
	end
	// Result side: takes the oldest note whenever the block hands over a sample
	always @(posedge MCLK) begin
		if (sv === 1'b1) begin
			if (notes.size() == 0)
				check(0, 1);
			else
				check(32'({schan, sdata}), 32'(notes.pop_front()));
			if (spost === 1'b1)
				post_n++;
			else begin
				check(32'(post_n), 0);
				pre_n++;
			end
		end
	end
	initial begin
		repeat (5) @(posedge MCLK);
		RSTN <= 1'b1;
		wb(1'b1, 8'hfc, xs());
		wb(1'b0, 8'hfc, 0);
		check(rd, 0);
		wb(1'b1, OFS_SMP_DIV, 11);
		wb(1'b1, OFS_RETRIG_DIV, 99);
		wb(1'b1, OFS_SCAN_CNT, 2);
		wb(1'b1, OFS_POST_CNT, 6);
		wb(1'b1, OFS_BLK_SIZE, 32'hffff);
		wb(1'b1, OFS_IRQ_MASK, 32'h1 << IRQ_DONE);
		for (int i = 0; i < 3; i++)
			run(i);
		halt();
		slow <= 1'b1;
		err(IRQ_OVS, 1'b0);
		slow <= 1'b0;
		err(IRQ_FIFO_OVF, 1'b1);
		wb(1'b1, OFS_BLK_SIZE, 2);
		err(IRQ_HOST_OVF, 1'b0);
		summarize();
	end
	initial begin
		#200000;
		failures++;
		summarize();
	end
endmodule : tb_about_trigger_acq_control
bind atq_acq_ctrl atq_acq_props #(.RES(RES)) u_props (.MCLK(MCLK), .RSTN(RSTN), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .ADC_CONVST(ADC_CONVST), .ADC_CHAN(ADC_CHAN),
	.ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA), .FIFO_FULL(FIFO_FULL), .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA),
	.SMP_CHAN(SMP_CHAN), .SMP_POST(SMP_POST), .IRQ(IRQ));
